// ### src/scs_pkg.sv
// shared constants and types of the conversion sequencer
package scs_pkg;

	// ----------------------------------------------------------------
	// result word and step layout
	// ----------------------------------------------------------------
	localparam int SCS_BITS = 16;
	localparam logic [4:0] SCS_STEP_FIRST = 5'h00;
	localparam logic [4:0] SCS_STEP_LAST = 5'h10;
	localparam logic [4:0] SCS_STEP_ONE = 5'h01;
	localparam logic [4:0] SCS_PULSES = 5'h11;
	localparam logic [15:0] SCS_DATA_RESET = 16'hFFFF;
	localparam logic [15:0] SCS_DATA_INIT = 16'h7FFF;
	localparam logic [15:0] SCS_MSB_MASK = 16'h8000;
	localparam logic [15:0] SCS_ZERO = 16'h0000;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int SCS_TRIG_MIN_NS = 50;
	localparam int SCS_CONV_MAX_NS = 14000;
	localparam int SCS_SYS_PERIOD_NS = 40;
	localparam int SCS_LINK_PERIOD_NS = 64;
	// least time rounds up
	localparam int SCS_TRIG_MIN_CYC =
		(SCS_TRIG_MIN_NS + SCS_SYS_PERIOD_NS - 1) / SCS_SYS_PERIOD_NS;
	// longest time rounds down
	localparam int SCS_CONV_MAX_CYC = SCS_CONV_MAX_NS / SCS_LINK_PERIOD_NS;
	localparam logic [7:0] SCS_CONV_MAX = 8'(SCS_CONV_MAX_CYC);

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SCS_IDLE,
		SCS_HIGH,
		SCS_LOW
	} scs_state_t;

	// pins presented to the host
	typedef struct packed {
		logic status;
		logic gatedClk;
		logic [15:0] dataN;
	} scs_out_t;

endpackage : scs_pkg

// ### src/scs_sequencer.sv
// successive-approximation sequencer with gated clock and status
`timescale 1ns/1ps
// Contract
// - conversion starts on the trigger's falling edge, never its rising edge.
// - status goes high when the trigger is received; here it rises only after the trigger's trailing edge.
// - status high lets the gated clock run exactly 17 cycles.
// - trailing edge initialises result bits, status and clock inhibit.
// - first step clears the MSB and sets bits 2 to 16.
// - step k decides bit k and clears bit k+1, until step 16.
// - one bit per period, MSB first, kept or rejected by comparator.
// - status falls after the LSB decision, result then valid.
// - status low holds the gated clock low until next conversion.
// - each result bit is valid on the gated clock rising edge.
// - parallel output is negative true: one is low, zero is high.
// - coding is complementary binary or complementary offset binary.
// - result stands valid at least 20 ns before status falls.
// - a conversion ends within 14 us of the trailing edge.
module scs_sequencer (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic clkConv,
	input wire logic trigger,
	input wire logic compAbove,
	output scs_pkg::scs_out_t result
);

	// ----------------------------------------------------------------
	// system domain: trigger synchroniser and trailing edge
	// ----------------------------------------------------------------
	logic trigMeta;
	logic trigSync;
	logic trigLast;
	logic startTgl;
	wire trigFall = trigLast & ~trigSync;

	// a falling trigger flips the start toggle; rises do nothing
	always_ff @(posedge clk_sys) begin
		trigMeta <= trigger;
		trigSync <= trigMeta;
		if (reset) begin
			trigLast <= 1'b0;
			startTgl <= 1'b0;
		end else begin
			trigLast <= trigSync;
			startTgl <= startTgl ^ trigFall;
		end
	end

	// ----------------------------------------------------------------
	// converter domain: reset, start and comparator crossing
	// ----------------------------------------------------------------
	logic rstMeta;
	logic rstConv;
	logic tglMeta;
	logic tglSync;
	logic tglSeen;
	logic compMeta;
	logic compSync;

	// two flops for each level entering the converter clock
	always_ff @(posedge clkConv) begin
		rstMeta <= reset;
		rstConv <= rstMeta;
		tglMeta <= startTgl;
		tglSync <= tglMeta;
		compMeta <= compAbove;
		compSync <= compMeta;
	end

	// starts during a conversion are dropped, the host keeps it low
	always_ff @(posedge clkConv) begin
		if (rstConv) begin
			tglSeen <= 1'b0;
		end else begin
			tglSeen <= tglSync;
		end
	end

	// ----------------------------------------------------------------
	// bit decision logic
	// ----------------------------------------------------------------
	scs_pkg::scs_state_t state;
	logic [4:0] step;
	logic [4:0] pulseCnt;
	logic [7:0] convCnt;
	logic [15:0] next_dataN;
	wire startEvt = tglSync ^ tglSeen;
	wire [4:0] decShift = step - scs_pkg::SCS_STEP_ONE;
	wire [15:0] decMask = scs_pkg::SCS_MSB_MASK >> decShift;
	wire [15:0] clrMask = decMask >> 1;
	wire [15:0] rejMask = compSync ? scs_pkg::SCS_ZERO : decMask;
	wire [15:0] stepData = (result.dataN & ~clrMask) | rejMask;
	wire lastStep = (step == scs_pkg::SCS_STEP_LAST);

	// first step loads the trial word, later steps decide one bit
	always_comb begin
		if (step == scs_pkg::SCS_STEP_FIRST) begin
			next_dataN = scs_pkg::SCS_DATA_INIT;
		end else begin
			next_dataN = stepData;
		end
	end

	// ----------------------------------------------------------------
	// sequencer: one gated clock cycle is a high and a low phase
	// ----------------------------------------------------------------
	always_ff @(posedge clkConv) begin
		if (rstConv) begin
			state <= scs_pkg::SCS_IDLE;
			step <= scs_pkg::SCS_STEP_FIRST;
			result.status <= 1'b0;
			result.gatedClk <= 1'b0;
			result.dataN <= scs_pkg::SCS_DATA_RESET;
		end else begin
			unique case (state)
				scs_pkg::SCS_IDLE: begin
					result.gatedClk <= 1'b0;
					if (startEvt) begin
						result.status <= 1'b1;
						result.dataN <= scs_pkg::SCS_DATA_INIT;
						step <= scs_pkg::SCS_STEP_FIRST;
						state <= scs_pkg::SCS_HIGH;
					end
				end
				scs_pkg::SCS_HIGH: begin
					result.gatedClk <= 1'b1;
					result.dataN <= next_dataN;
					state <= scs_pkg::SCS_LOW;
				end
				scs_pkg::SCS_LOW: begin
					result.gatedClk <= 1'b0;
					if (lastStep) begin
						result.status <= 1'b0;
						state <= scs_pkg::SCS_IDLE;
					end else begin
						step <= step + scs_pkg::SCS_STEP_ONE;
						state <= scs_pkg::SCS_HIGH;
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// helper counters read only by the checks below
	// ----------------------------------------------------------------
	always_ff @(posedge clkConv) begin
		if (rstConv || (state == scs_pkg::SCS_IDLE && startEvt)) begin
			pulseCnt <= 5'h00;
			convCnt <= 8'h00;
		end else begin
			if (state == scs_pkg::SCS_HIGH) begin
				pulseCnt <= pulseCnt + 5'h01;
			end
			if (result.status) begin
				convCnt <= convCnt + 8'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	start_init_a: assert property (
		@(posedge clkConv) disable iff (rstConv)
		(state == scs_pkg::SCS_IDLE && startEvt) |=> result.status
			&& !result.gatedClk && result.dataN == 16'h7FFF)
		else $error("start did not raise status with trial word");

	clk_inhibit_a: assert property (
		@(posedge clkConv) disable iff (rstConv)
		!result.status |-> !result.gatedClk)
		else $error("gated clock high while status low");

	pulse_count_a: assert property (
		@(posedge clkConv) disable iff (rstConv)
		$fell(result.status) |-> pulseCnt == 5'h11)
		else $error("gated clock did not run 17 cycles");

	first_step_a: assert property (
		@(posedge clkConv) disable iff (rstConv)
		$rose(result.gatedClk) && step == 5'h00
			|-> result.dataN == 16'h7FFF)
		else $error("first step did not load trial word");

	bit_decide_a: assert property (
		@(posedge clkConv) disable iff (rstConv)
		(state == scs_pkg::SCS_HIGH && step != 5'h00)
			|=> result.dataN[16 - $past(step)] == !$past(compSync)
			&& (($past(step) == 5'h10)
			|| !result.dataN[15 - $past(step)]))
		else $error("bit decision or next trial bit wrong");

	data_edge_a: assert property (
		@(posedge clkConv) disable iff (rstConv)
		$changed(result.dataN) |-> $rose(result.gatedClk)
			|| $rose(result.status))
		else $error("data changed away from a clock rise");

	status_fall_a: assert property (
		@(posedge clkConv) disable iff (rstConv)
		$fell(result.status) |-> $past(result.gatedClk)
			&& $stable(result.dataN) && step == 5'h10)
		else $error("status fell before the last decision settled");

	conv_time_a: assert property (
		@(posedge clkConv) disable iff (rstConv)
		result.status |-> convCnt < scs_pkg::SCS_CONV_MAX)
		else $error("conversion ran past its longest time");

	trig_edge_a: assert property (
		@(posedge clk_sys) disable iff (reset)
		$fell(trigLast) |-> $changed(startTgl))
		else $error("trailing edge did not start a conversion");

	trig_rise_a: assert property (
		@(posedge clk_sys) disable iff (reset)
		$rose(trigLast) |-> $stable(startTgl))
		else $error("rising trigger started a conversion");

	// ----------------------------------------------------------------
	// sequencing checks
	// ----------------------------------------------------------------
	// these watch the phase machine that the pin checks above only see
	// from outside, so a broken step or phase shows up where it starts
	status_busy_a: assert property (
		@(posedge clkConv) disable iff (rstConv)
		result.status == (state != scs_pkg::SCS_IDLE))
		else $error("status disagrees with the sequencer state");

	idle_clk_a: assert property (
		@(posedge clkConv) disable iff (rstConv)
		state == scs_pkg::SCS_IDLE |-> !result.gatedClk)
		else $error("gated clock high while idle");

	high_phase_a: assert property (
		@(posedge clkConv) disable iff (rstConv)
		state == scs_pkg::SCS_HIGH |=> $rose(result.gatedClk))
		else $error("gated clock did not rise in the high phase");

	low_phase_a: assert property (
		@(posedge clkConv) disable iff (rstConv)
		state == scs_pkg::SCS_LOW |=> $fell(result.gatedClk))
		else $error("gated clock did not fall in the low phase");

	step_range_a: assert property (
		@(posedge clkConv) disable iff (rstConv)
		step <= scs_pkg::SCS_STEP_LAST)
		else $error("step ran past the last bit");

	step_next_a: assert property (
		@(posedge clkConv) disable iff (rstConv)
		(state == scs_pkg::SCS_LOW && !lastStep)
			|=> step == $past(step) + 5'h01)
		else $error("step did not advance by one");

	last_stop_a: assert property (
		@(posedge clkConv) disable iff (rstConv)
		(state == scs_pkg::SCS_LOW && lastStep)
			|=> !result.status && state == scs_pkg::SCS_IDLE)
		else $error("sequencer did not stop after the last bit");

	idle_hold_a: assert property (
		@(posedge clkConv) disable iff (rstConv)
		(state == scs_pkg::SCS_IDLE && !startEvt) |=> $stable(result.dataN))
		else $error("result moved while the converter was idle");

	first_load_a: assert property (
		@(posedge clkConv) disable iff (rstConv)
		(state == scs_pkg::SCS_HIGH && step == scs_pkg::SCS_STEP_FIRST)
			|=> result.dataN == scs_pkg::SCS_DATA_INIT)
		else $error("first step did not present the trial word");

	comp_keep_a: assert property (
		@(posedge clkConv) disable iff (rstConv)
		(state == scs_pkg::SCS_HIGH && step != 5'h00 && compSync)
			|=> !result.dataN[16 - $past(step)])
		else $error("kept bit not driven low");

	comp_reject_a: assert property (
		@(posedge clkConv) disable iff (rstConv)
		(state == scs_pkg::SCS_HIGH && step != 5'h00 && !compSync)
			|=> result.dataN[16 - $past(step)])
		else $error("rejected bit not driven high");

	// 34 converter edges pass from the start to the last low phase
	conv_len_a: assert property (
		@(posedge clkConv) disable iff (rstConv)
		$fell(result.status) |-> convCnt == 8'h22)
		else $error("conversion length is not 34 converter cycles");

	reset_idle_a: assert property (
		@(posedge clkConv)
		rstConv |=> !result.status && !result.gatedClk
			&& result.dataN == scs_pkg::SCS_DATA_RESET)
		else $error("reset did not park the outputs idle");

	trig_quiet_a: assert property (
		@(posedge clk_sys) disable iff (reset)
		!trigFall |=> $stable(startTgl))
		else $error("start toggle moved without a trailing edge");

endmodule : scs_sequencer

// ### sim/scs_host_model.sv
// host controller model: trigger pulses and result latch
`timescale 1ns/1ps
module scs_host_model (
	input wire logic clk_sys,
	input wire logic fire,
	input wire logic [7:0] width,
	input wire scs_pkg::scs_out_t result,
	output logic trigger,
	output logic [15:0] latched
);
	logic [7:0] left = 8'h00;
	initial trigger = 1'b0;
	// pulse high for width cycles, then hold low through the conversion
	always @(posedge clk_sys) begin
		if (fire && !trigger) begin
			trigger <= 1'b1;
			left <= width;
		end else if (left > 8'h01) begin
			left <= left - 8'h01;
		end else begin
			trigger <= 1'b0;
		end
	end
	// capture the word as status falls
	always @(negedge result.status) latched <= result.dataN;
endmodule : scs_host_model

// ### sim/scs_sequencer_tb.sv
// self-checking bench of the conversion sequencer
`timescale 1ns/1ps
module scs_sequencer_tb;
	logic clk_sys = 1'b0;
	logic clkConv = 1'b0;
	logic reset = 1'b1;
	logic compAbove = 1'b0;
	logic fire = 1'b0;
	logic [7:0] width = 8'h02;
	logic trigger;
	logic [15:0] latched;
	scs_pkg::scs_out_t result;
	int err_count = 0;
	int compares = 0;

	// system clock 40 ns, converter clock 64 ns at an unrelated phase
	always #20 clk_sys = ~clk_sys;
	initial #13 forever #32 clkConv = ~clkConv;

	scs_sequencer i_scs_sequencer (.clk_sys(clk_sys), .reset(reset),
		.clkConv(clkConv), .trigger(trigger), .compAbove(compAbove),
		.result(result));
	scs_host_model i_scs_host_model (.clk_sys(clk_sys), .fire(fire),
		.width(width), .result(result), .trigger(trigger),
		.latched(latched));

	// ----------------------------------------------------------------
	// checking and verdict
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic give_verdict;
		if (err_count == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : give_verdict

	// one conversion with a steady comparator, judged at the pins
	task automatic convert(input logic keep, input logic [7:0] len,
		input logic [15:0] expData);
		int n;
		int pulses;
		logic prevClk;
		logic [15:0] first;
		n = 0;
		pulses = 0;
		prevClk = 1'b0;
		first = 16'h0000;
		@(posedge clk_sys);
		compAbove <= keep;
		width <= len;
		fire <= 1'b1;
		@(posedge clk_sys);
		fire <= 1'b0;
		// nothing starts while the pulse is still high
		do begin
			@(negedge clk_sys);
			check("early status", 16'h0000, 16'(result.status));
		end while (trigger === 1'b1);
		while (result.status !== 1'b1 && n < 20) begin
			@(negedge clk_sys);
			n++;
		end
		check("start", 16'h0001, 16'(result.status));
		n = 0;
		// count gated clock pulses and time until status falls
		while (result.status === 1'b1 && n < 400) begin
			@(negedge clk_sys);
			n++;
			if (result.gatedClk === 1'b1 && prevClk === 1'b0) begin
				if (pulses == 0) first = result.dataN;
				pulses++;
			end
			prevClk = result.gatedClk;
		end
		check("first trial", 16'h7FFF, first);
		check("pulses", 16'h0011, 16'(pulses));
		check("in time", 16'h0001, 16'(n * 40 <= 14000));
		check("result", expData, result.dataN);
		check("latched", expData, latched);
		repeat (4) @(negedge clk_sys);
		check("clock parked", 16'h0000, 16'(result.gatedClk));
	endtask : convert

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (16) @(posedge clk_sys);
		reset <= 1'b0;
		@(negedge clk_sys);
		check("idle", 16'h0000, {14'h0000, result.status, result.gatedClk});
		check("idle data", 16'hFFFF, result.dataN);
		convert(1'b1, 8'h02, 16'h0000);
		convert(1'b0, 8'h14, 16'hFFFF);
		give_verdict();
	end

	// watchdog against a hung conversion
	initial begin
		#400000;
		err_count++;
		give_verdict();
	end
endmodule : scs_sequencer_tb
